// ===== sgcg_chipset.sv
// chipset-side model: drives power requests and die temperature, counts acknowledges
`timescale 1ns/1ps
module sgcg_chipset (
  input  wire logic       clock_i,
  input  wire logic       ack_i,
  output logic            stop_clock_request_n_o,
  output logic            sleep_request_n_o,
  output logic            deep_sleep_request_n_o,
  output logic [7:0]      die_temp_o,
  output logic            bus_clock_present_o
);
  int ack_count = 0;

  initial begin
    {stop_clock_request_n_o, sleep_request_n_o, deep_sleep_request_n_o} = 3'h7;
    die_temp_o          = 8'h20;
    bus_clock_present_o = 1'b1;
  end

  // one count per acknowledge cycle, so a stretched pulse shows as extra counts
  always @(posedge clock_i) begin
    if (ack_i === 1'b1) ack_count <= ack_count + 1;
  end

  // requests move just after a falling edge so the block never samples them mid-change
  task automatic drive(input logic [2:0] req_n, input logic [7:0] temp);
    @(negedge clock_i);
    {stop_clock_request_n_o, sleep_request_n_o, deep_sleep_request_n_o} = req_n;
    die_temp_o = temp;
  endtask
endmodule

// ===== sgcg_pkg.sv
// shared constants and state encoding for the stop-grant clock gating block
package sgcg_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam logic [7:0]  TRIP_TEMP_C     = 8'h7D;
  localparam int unsigned TRIP_FILTER_NS  = 16;
  localparam int unsigned TRIP_FILTER_CYC = (TRIP_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0]  SYNC_RESET      = 3'h7;

  typedef enum logic [2:0] {
    SGCG_RUN        = 3'b000,
    SGCG_STOP_GRANT = 3'b001,
    SGCG_SLEEP      = 3'b010,
    SGCG_DEEP_SLEEP = 3'b011,
    SGCG_TRIPPED    = 3'b100
  } sgcg_state_t;
endpackage

// ===== sgcg_sync.sv
// two-flop synchroniser for a group of active-low request inputs
`timescale 1ns/1ps
module sgcg_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // requests idle high, so reset to the inactive level
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_o   <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

// ===== sgcg_top.sv
// stop-grant, sleep and thermal trip power state control
`timescale 1ns/1ps
module sgcg_top (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       stop_clock_request_n_i,
  input  wire logic       sleep_request_n_i,
  input  wire logic       deep_sleep_request_n_i,
  input  wire logic [7:0] die_temp_i,
  input  wire logic       bus_clock_present_i,
  output logic            core_clock_en_o,
  output logic            bus_clock_en_o,
  output logic            intc_clock_en_o,
  output logic            snoop_en_o,
  output logic            intr_service_en_o,
  output logic            exec_en_o,
  output logic            stop_grant_ack_o,
  output logic            thermal_trip_out_n_o,
  output logic [2:0]      power_state_o
);
  logic [2:0]          req_sync;
  logic                stop_req;
  logic                sleep_req;
  logic                deep_req;
  logic                hot_now;
  logic [3:0]          hot_cnt_reg;
  logic                trip_reg;
  sgcg_pkg::sgcg_state_t state_reg;
  sgcg_pkg::sgcg_state_t state_next;

  // true in the states where the bus side keeps its clocks and still answers
  function automatic logic bus_side_awake(input sgcg_pkg::sgcg_state_t st);
    return (st == sgcg_pkg::SGCG_RUN) || (st == sgcg_pkg::SGCG_STOP_GRANT);
  endfunction

  sgcg_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  ({deep_sleep_request_n_i, sleep_request_n_i, stop_clock_request_n_i}),
    .sync_o   (req_sync)
  );

  assign stop_req  = ~req_sync[0];
  assign sleep_req = ~req_sync[1];
  assign deep_req  = ~req_sync[2];
  assign hot_now   = die_temp_i > sgcg_pkg::TRIP_TEMP_C;

  // a short filter keeps a single noisy sensor sample from tripping the part
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hot_cnt_reg <= 4'h0;
    end else if (!hot_now) begin
      hot_cnt_reg <= 4'h0;
    end else if (hot_cnt_reg < 4'(sgcg_pkg::TRIP_FILTER_CYC)) begin
      hot_cnt_reg <= hot_cnt_reg + 4'h1;
    end
  end

  // trip is sticky until reset: the part must not resume while still cooking
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trip_reg <= 1'b0;
    end else if (hot_cnt_reg >= 4'(sgcg_pkg::TRIP_FILTER_CYC)) begin
      trip_reg <= 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sgcg_pkg::SGCG_RUN: begin
        if (stop_req) begin
          state_next = sgcg_pkg::SGCG_STOP_GRANT;
        end
      end
      sgcg_pkg::SGCG_STOP_GRANT: begin
        if (sleep_req) begin
          state_next = sgcg_pkg::SGCG_SLEEP;
        end else if (!stop_req) begin
          state_next = sgcg_pkg::SGCG_RUN;
        end
      end
      sgcg_pkg::SGCG_SLEEP: begin
        if (deep_req) begin
          state_next = sgcg_pkg::SGCG_DEEP_SLEEP;
        end else if (!sleep_req) begin
          state_next = sgcg_pkg::SGCG_STOP_GRANT;
        end
      end
      sgcg_pkg::SGCG_DEEP_SLEEP: begin
        // deep sleep falls back to sleep once its request is withdrawn
        if (!deep_req) begin
          state_next = sgcg_pkg::SGCG_SLEEP;
        end
      end
      sgcg_pkg::SGCG_TRIPPED: begin
        state_next = sgcg_pkg::SGCG_TRIPPED;
      end
      default: begin
        state_next = sgcg_pkg::SGCG_RUN;
      end
    endcase
    if (trip_reg) begin
      state_next = sgcg_pkg::SGCG_TRIPPED;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= sgcg_pkg::SGCG_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs registered from the next state so they line up with state_reg
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_clock_en_o   <= 1'b1;
      bus_clock_en_o    <= 1'b1;
      intc_clock_en_o   <= 1'b1;
      snoop_en_o        <= 1'b1;
      intr_service_en_o <= 1'b1;
      exec_en_o         <= 1'b1;
      power_state_o     <= 3'h0;
    end else begin
      power_state_o     <= state_next;
      core_clock_en_o   <= state_next == sgcg_pkg::SGCG_RUN;
      exec_en_o         <= state_next == sgcg_pkg::SGCG_RUN;
      // bus clock only stops in sleep states and after a trip, never for the stop request
      bus_clock_en_o    <= bus_side_awake(state_next);
      intc_clock_en_o   <= bus_side_awake(state_next);
      snoop_en_o        <= bus_side_awake(state_next);
      intr_service_en_o <= bus_side_awake(state_next);
    end
  end

  // acknowledge only on entry from run, not on return from sleep
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_grant_ack_o <= 1'b0;
    end else begin
      stop_grant_ack_o <= (state_reg == sgcg_pkg::SGCG_RUN) && (state_next == sgcg_pkg::SGCG_STOP_GRANT);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      thermal_trip_out_n_o <= 1'b1;
    end else begin
      thermal_trip_out_n_o <= ~trip_reg;
    end
  end

  a_stop_enter: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_RUN && stop_req && !trip_reg) |=> state_reg == sgcg_pkg::SGCG_STOP_GRANT)
    else $error("stop request did not enter stop-grant");
  a_ack_pulse: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_RUN && state_next == sgcg_pkg::SGCG_STOP_GRANT) |=> stop_grant_ack_o ##1 !stop_grant_ack_o)
    else $error("acknowledge not a single pulse on entry");
  a_gate_core: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_reg == sgcg_pkg::SGCG_STOP_GRANT |-> !core_clock_en_o && intc_clock_en_o)
    else $error("core clock not gated in stop-grant");
  a_snoop_kept: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_reg == sgcg_pkg::SGCG_STOP_GRANT |-> snoop_en_o && intr_service_en_o)
    else $error("snoop or interrupts lost in stop-grant");
  a_resume_run: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_STOP_GRANT && !stop_req && !sleep_req && !trip_reg) |=> core_clock_en_o && exec_en_o)
    else $error("clocks not restarted on release");
  a_bus_alive: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_RUN || state_reg == sgcg_pkg::SGCG_STOP_GRANT) |-> bus_clock_en_o)
    else $error("bus clock stopped by stop request");
  a_trip_pin: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(trip_reg) |=> !thermal_trip_out_n_o && !exec_en_o ##1 !thermal_trip_out_n_o)
    else $error("thermal trip not signalled");
  a_sleep_enter: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_STOP_GRANT && sleep_req && !trip_reg) |=> !snoop_en_o && !bus_clock_en_o)
    else $error("sleep entry did not stop clocks");
  a_sleep_exit: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_SLEEP && !sleep_req && !deep_req && !trip_reg) |=>
      state_reg == sgcg_pkg::SGCG_STOP_GRANT && bus_clock_en_o && !stop_grant_ack_o)
    else $error("sleep release did not return to stop-grant");
  a_deep_enter: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_SLEEP && deep_req && !trip_reg) |=> state_reg == sgcg_pkg::SGCG_DEEP_SLEEP)
    else $error("deep sleep not entered");
  a_sync_delay: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == sgcg_pkg::SGCG_RUN && $fell(stop_clock_request_n_i) && !stop_req && !trip_reg) |=>
      state_reg == sgcg_pkg::SGCG_RUN)
    else $error("stop request used before synchronisation");
  a_ack_at_entry: assert property (@(posedge clock_i) disable iff (!resetn_i)
    stop_grant_ack_o |-> state_reg == sgcg_pkg::SGCG_STOP_GRANT)
    else $error("acknowledge outside stop-grant entry");
  a_trip_sticky: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !thermal_trip_out_n_o |=> !thermal_trip_out_n_o)
    else $error("thermal trip released before reset");
  a_trip_halts: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_reg == sgcg_pkg::SGCG_TRIPPED |-> !exec_en_o && !core_clock_en_o)
    else $error("execution not halted after trip");
  a_sleep_deaf: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_reg == sgcg_pkg::SGCG_SLEEP |-> !snoop_en_o && !intr_service_en_o)
    else $error("snoops or interrupts honoured in sleep");
  a_deep_dark: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_reg == sgcg_pkg::SGCG_DEEP_SLEEP |-> !core_clock_en_o && !bus_clock_en_o)
    else $error("clocks running in deep sleep");

  c_stop_grant: cover property (@(posedge clock_i) disable iff (!resetn_i) stop_grant_ack_o);
  c_sleep:      cover property (@(posedge clock_i) disable iff (!resetn_i) state_reg == sgcg_pkg::SGCG_SLEEP);
  c_deep:       cover property (@(posedge clock_i) disable iff (!resetn_i) state_reg == sgcg_pkg::SGCG_DEEP_SLEEP);
  c_trip:       cover property (@(posedge clock_i) disable iff (!resetn_i) !thermal_trip_out_n_o);
  c_wake:       cover property (@(posedge clock_i) disable iff (!resetn_i)
    state_reg == sgcg_pkg::SGCG_SLEEP ##1 state_reg == sgcg_pkg::SGCG_STOP_GRANT);
endmodule

// ===== test_stop_grant_clock_gating.sv
// self-checking bench for stop-grant, sleep and thermal trip control
`timescale 1ns/1ps
module test_stop_grant_clock_gating;
  // {state, core, bus, intc, snoop, intr, exec, ack, trip_n}
  localparam logic [10:0] V_RUN   = 11'h0FD;
  localparam logic [10:0] V_SGA   = 11'h17B;
  localparam logic [10:0] V_SGN   = 11'h179;
  localparam logic [10:0] V_SLEEP = 11'h201;
  localparam logic [10:0] V_DEEP  = 11'h301;
  localparam logic [10:0] V_TRIP  = 11'h400;
  logic        clock_i;
  logic        resetn_i;
  logic        stop_n;
  logic        sleep_n;
  logic        deep_n;
  logic        bus_present;
  logic [7:0]  temp;
  logic [5:0]  en;
  logic        ack;
  logic        trip_n;
  logic [2:0]  state;
  logic [10:0] obs;
  int          mismatches = 0;
  int          n_checks = 0;

  assign obs = {state, en[5:0], ack, trip_n};

  sgcg_chipset u_sgcg_chipset (.clock_i(clock_i), .ack_i(ack), .stop_clock_request_n_o(stop_n),
    .sleep_request_n_o(sleep_n), .deep_sleep_request_n_o(deep_n), .die_temp_o(temp),
    .bus_clock_present_o(bus_present));

  sgcg_top u_sgcg_top (.clock_i(clock_i), .resetn_i(resetn_i), .stop_clock_request_n_i(stop_n),
    .sleep_request_n_i(sleep_n), .deep_sleep_request_n_i(deep_n), .die_temp_i(temp),
    .bus_clock_present_i(bus_present), .core_clock_en_o(en[5]), .bus_clock_en_o(en[4]),
    .intc_clock_en_o(en[3]), .snoop_en_o(en[2]), .intr_service_en_o(en[1]), .exec_en_o(en[0]),
    .stop_grant_ack_o(ack), .thermal_trip_out_n_o(trip_n), .power_state_o(state));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // counts are from the previous check, or from the falling edge on which the last request moved
  task automatic chk(input int n, input logic [10:0] exp);
    repeat (n) @(negedge clock_i);
    n_checks++;
    if (obs !== exp) begin
      mismatches++;
      $display("BAD outputs expected %h seen %h", exp, obs);
    end
  endtask

  task automatic go(input logic [2:0] r, input logic [7:0] t);
    u_sgcg_chipset.drive(r, t);
  endtask

  task automatic apply_reset;
    @(negedge clock_i);
    resetn_i = 1'b0;
    repeat (12) @(negedge clock_i);
    resetn_i = 1'b1;
  endtask

  task automatic s_sleep_refused;
    go(3'h5, 8'h20);
    chk(8, V_RUN);
    go(3'h7, 8'h20);
    chk(4, V_RUN);
  endtask

  task automatic s_stop;
    go(3'h3, 8'h20);
    chk(2, V_RUN);
    chk(1, V_SGA);
    chk(1, V_SGN);
    go(3'h7, 8'h20);
    chk(4, V_RUN);
  endtask

  task automatic s_sleep;
    go(3'h3, 8'h20);
    chk(5, V_SGN);
    go(3'h1, 8'h20);
    chk(4, V_SLEEP);
    go(3'h5, 8'h20);
    chk(4, V_SLEEP);
    go(3'h4, 8'h20);
    chk(4, V_DEEP);
    go(3'h5, 8'h20);
    chk(4, V_SLEEP);
    go(3'h1, 8'h20);
    chk(4, V_SLEEP);
    go(3'h3, 8'h20);
    chk(4, V_SGN);
    go(3'h7, 8'h20);
    chk(4, V_RUN);
    n_checks++;
    if (u_sgcg_chipset.ack_count != 2) begin
      mismatches++;
      $display("BAD ack_count expected 2 seen %0d", u_sgcg_chipset.ack_count);
    end
  endtask

  task automatic s_trip;
    go(3'h7, sgcg_pkg::TRIP_TEMP_C);
    chk(8, V_RUN);
    go(3'h7, 8'h7E);
    go(3'h7, 8'h20);
    chk(8, V_RUN);
    go(3'h7, 8'h7E);
    chk(3, V_RUN);
    chk(1, V_TRIP);
    go(3'h3, 8'h20);
    chk(8, V_TRIP);
    apply_reset();
    chk(1, V_RUN);
  endtask

  initial begin
    resetn_i = 1'b0;
    apply_reset();
    chk(1, V_RUN);
    s_sleep_refused();
    s_stop();
    s_sleep();
    s_trip();
    conclude();
  end

  // a stuck sequence is cut short and counted against the run
  initial begin
    repeat (3000) @(posedge clock_i);
    mismatches++;
    conclude();
  end
endmodule
